// ==== verilog/irq_prio_pkg.sv ====
// shared constants and types for the interrupt priority fields block
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] EXT_IRQ_PRIORITY_OFS        = 4'h0;
  localparam logic [3:0] PWM_GEN_2_TO_4_PRIORITY_OFS = 4'h1;
  localparam logic [3:0] CHANGE_NOTIFY_PRIORITY_OFS  = 4'h2;

  // ----------------------------------------------------------------
  // field positions (low bit of each 3-bit field)
  // ----------------------------------------------------------------
  localparam int EXT_IRQ1_PRIO_POS      = 0;
  localparam int EXT_IRQ2_PRIO_POS      = 4;
  localparam int PULSE_GEN2_PRIO_POS    = 0;
  localparam int PULSE_GEN3_PRIO_POS    = 4;
  localparam int PULSE_GEN4_PRIO_POS    = 8;
  localparam int CHANGE_NOTIFY_PRIO_POS = 12;

  // ----------------------------------------------------------------
  // levels and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  PRIO_RESET    = 3'h4;
  localparam logic [2:0]  PRIO_DISABLED = 3'h0;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // source numbering
  // ----------------------------------------------------------------
  localparam int          NUM_SRC       = 6;
  localparam logic [2:0]  SRC_EXT_IRQ1  = 3'h0;
  localparam logic [2:0]  SRC_EXT_IRQ2  = 3'h1;
  localparam logic [2:0]  SRC_PULSE_G2  = 3'h2;
  localparam logic [2:0]  SRC_PULSE_G3  = 3'h3;
  localparam logic [2:0]  SRC_PULSE_G4  = 3'h4;
  localparam logic [2:0]  SRC_CHG_NTFY  = 3'h5;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] id;
    logic [2:0] level;
  } irq_sel_t;

  typedef struct packed {
    logic [2:0]  ext_irq1_prio;
    logic [2:0]  ext_irq2_prio;
    logic [2:0]  pulse_gen2_prio;
    logic [2:0]  pulse_gen3_prio;
    logic [2:0]  pulse_gen4_prio;
    logic [2:0]  change_notify_prio;
    logic [15:0] rdata;
    irq_sel_t    sel;
  } prio_state_t;

endpackage : irq_prio_pkg

// ==== verilog/interrupt_priority_fields.sv ====
// priority fields for six interrupt sources, with a highest-level selector
//
// Notes on behaviour
// R1: field value is the priority level directly
// R2: all-zero field disables the source
// R3: unimplemented bits ignore writes, read zero
// R4: pwm reg bits 15-11 unused, 10-8 gen4
// R5: pwm reg bit 7 unused, 6-4 gen3
// R6: pwm reg bits 2-0 gen2, bit 3 unused
// R7: every field resets to level 4
// R8: ext reg: irq2 bits 6-4, irq1 2-0
// R9: change-notify reg: only bits 14-12 implemented
// R10: highest enabled pending level is presented
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module interrupt_priority_fields
  import irq_prio_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  // register port
  input  reg_req_t                  bus_req_i,
  output logic [15:0]               rdata_o,
  // interrupt sources, same clock domain
  input  wire logic [NUM_SRC-1:0]   pending_i,
  // selected source
  output irq_sel_t                  irq_sel_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // place a 3-bit field at its position in a 16-bit word
  function automatic logic [15:0] put_field(input logic [2:0] f,
                                            input int         pos);
    logic [15:0] w;
    w = 16'h0000;
    w[pos +: 3] = f;
    return w;
  endfunction : put_field

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prio_state_t st;
  prio_state_t next_st;

  logic [2:0] lvl [NUM_SRC];

  always_comb begin
    lvl[SRC_EXT_IRQ1] = st.ext_irq1_prio;
    lvl[SRC_EXT_IRQ2] = st.ext_irq2_prio;
    lvl[SRC_PULSE_G2] = st.pulse_gen2_prio;
    lvl[SRC_PULSE_G3] = st.pulse_gen3_prio;
    lvl[SRC_PULSE_G4] = st.pulse_gen4_prio;
    lvl[SRC_CHG_NTFY] = st.change_notify_prio;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    irq_sel_t best;
    best    = '0;
    next_st = st;

    // writes: only field bits are stored, the rest is dropped    // R3
    if (bus_req_i.wr) begin
      unique case (bus_req_i.addr)
        EXT_IRQ_PRIORITY_OFS: begin
          next_st.ext_irq2_prio =
            bus_req_i.wdata[EXT_IRQ2_PRIO_POS +: 3];                 // R8
          next_st.ext_irq1_prio =
            bus_req_i.wdata[EXT_IRQ1_PRIO_POS +: 3];                 // R8
        end
        PWM_GEN_2_TO_4_PRIORITY_OFS: begin
          next_st.pulse_gen4_prio =
            bus_req_i.wdata[PULSE_GEN4_PRIO_POS +: 3];               // R4
          next_st.pulse_gen3_prio =
            bus_req_i.wdata[PULSE_GEN3_PRIO_POS +: 3];               // R5
          next_st.pulse_gen2_prio =
            bus_req_i.wdata[PULSE_GEN2_PRIO_POS +: 3];               // R6
        end
        CHANGE_NOTIFY_PRIORITY_OFS: begin
          next_st.change_notify_prio =
            bus_req_i.wdata[CHANGE_NOTIFY_PRIO_POS +: 3];            // R9
        end
        default: begin
          // unmapped write is ignored
        end
      endcase
    end

    // reads: data valid only in the cycle after the strobe
    next_st.rdata = RDATA_RESET;
    if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        EXT_IRQ_PRIORITY_OFS:
          next_st.rdata = put_field(st.ext_irq2_prio, EXT_IRQ2_PRIO_POS)
                        | put_field(st.ext_irq1_prio,
                                    EXT_IRQ1_PRIO_POS);              // R8
        PWM_GEN_2_TO_4_PRIORITY_OFS:
          next_st.rdata =
              put_field(st.pulse_gen4_prio, PULSE_GEN4_PRIO_POS)     // R4
            | put_field(st.pulse_gen3_prio, PULSE_GEN3_PRIO_POS)     // R5
            | put_field(st.pulse_gen2_prio, PULSE_GEN2_PRIO_POS);    // R6
        CHANGE_NOTIFY_PRIORITY_OFS:
          next_st.rdata = put_field(st.change_notify_prio,
                                    CHANGE_NOTIFY_PRIO_POS);         // R9
        default:
          next_st.rdata = RDATA_RESET;                               // R3
      endcase
    end

    // selector: strict compare keeps the lowest source number on a tie,
    // so ties resolve the same way every cycle
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pending_i[i] && lvl[i] != PRIO_DISABLED                    // R2
          && lvl[i] > best.level) begin                              // R10
        best.valid = 1'b1;
        best.id    = 3'(i);
        best.level = lvl[i];                                         // R1
      end
    end
    next_st.sel = best;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st                    <= '0;
      st.ext_irq1_prio      <= PRIO_RESET;                           // R7
      st.ext_irq2_prio      <= PRIO_RESET;                           // R7
      st.pulse_gen2_prio    <= PRIO_RESET;                           // R7
      st.pulse_gen3_prio    <= PRIO_RESET;                           // R7
      st.pulse_gen4_prio    <= PRIO_RESET;                           // R7
      st.change_notify_prio <= PRIO_RESET;                           // R7
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rdata_o   = st.rdata;
  assign irq_sel_o = st.sel;

endmodule : interrupt_priority_fields

// ==== verif/interrupt_priority_fields_chk.sv ====
// port checker for the priority fields block
`timescale 1ns/1ps
module interrupt_priority_fields_chk
  import irq_prio_pkg::*;
(
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire logic               ce_i,
  input reg_req_t                bus_req_i,
  input logic [15:0]             rdata_o,
  input wire logic [NUM_SRC-1:0] pending_i,
  input irq_sel_t                irq_sel_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic wr;
  assign rd = ce_i && bus_req_i.rd;
  assign wr = ce_i && bus_req_i.wr;
  AST_IDLE_ZERO: assert property (
    ce_i && !bus_req_i.rd |=> rdata_o == 16'h0)
    else $error("read data not zero without read");
  AST_UNMAPPED: assert property (
    rd && bus_req_i.addr > 4'h2 |=> rdata_o == 16'h0)
    else $error("unmapped read not zero");
  AST_EXT_FIELDS: assert property (
    wr && bus_req_i.addr == 4'h0 ##1 rd && bus_req_i.addr == 4'h0
    |=> rdata_o == ($past(bus_req_i.wdata, 2) & 16'h0077))
    else $error("ext register readback wrong");
  AST_PWM_FIELDS: assert property (
    wr && bus_req_i.addr == 4'h1 ##1 rd && bus_req_i.addr == 4'h1
    |=> rdata_o == ($past(bus_req_i.wdata, 2) & 16'h0777))
    else $error("pwm register readback wrong");
  AST_CN_FIELDS: assert property (
    wr && bus_req_i.addr == 4'h2 ##1 rd && bus_req_i.addr == 4'h2
    |=> rdata_o == ($past(bus_req_i.wdata, 2) & 16'h7000))
    else $error("change notify readback wrong");
  AST_NONE_IDLE: assert property (
    ce_i && pending_i == 6'h0 |=> !irq_sel_o.valid)
    else $error("selection without pending source");
  AST_LEVEL_ON: assert property (
    irq_sel_o.valid |-> irq_sel_o.level != 3'h0)
    else $error("disabled source selected");
  AST_SEL_PEND: assert property (irq_sel_o.valid && $past(ce_i) |->
    $past(pending_i) != 6'h0) else $error("valid without pending");
  cover property (wr && bus_req_i.addr == 4'h1);
  cover property (rd && bus_req_i.addr == 4'h2);
  cover property (irq_sel_o.valid && irq_sel_o.level == 3'h7);
endmodule : interrupt_priority_fields_chk

bind interrupt_priority_fields interrupt_priority_fields_chk u_chk (
  .core_clk_i, .rst_n_i, .ce_i, .bus_req_i, .rdata_o, .pending_i, .irq_sel_o);

// ==== verif/test_interrupt_priority_fields.sv ====
// self-checking bench for the priority fields block
`timescale 1ns/1ps
module test_interrupt_priority_fields
  import irq_prio_pkg::*;
;
  logic        core_clk_i = 0;
  logic        rst_n_i = 0;
  reg_req_t    req = '0;
  logic [15:0] rdata;
  logic [5:0]  pend = '0;
  irq_sel_t    sel;
  logic [15:0] img [3] = '{16'h0044, 16'h0444, 16'h4000};
  logic [15:0] msk [3] = '{16'h0077, 16'h0777, 16'h7000};
  int          pos [6] = '{0, 4, 16, 20, 24, 44};
  int          due_q [$];
  logic [16:0] exp_q [$];
  int          cyc = 0;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [31:0] r = 32'h472d;
  // clock enable tied high: freezing is outside the documented fields
  interrupt_priority_fields dut (.core_clk_i, .rst_n_i, .ce_i(1'b1),
    .bus_req_i(req), .rdata_o(rdata), .pending_i(pend), .irq_sel_o(sel));
  initial forever #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req <= '{{2'b0, a}, d, w, !w};
    if (w && a < 3) img[a] = d & msk[a];
    if (!w) begin
      due_q.push_back(cyc + 2);
      exp_q.push_back({1'b0, a < 3 ? img[a] : 16'h0});
    end
  endtask : acc
  // tie goes to the lowest source number, so scan downward with >=
  function automatic logic [6:0] pick(input logic [5:0] p);
    logic [47:0] f;
    logic [6:0]  b;
    f = {img[2], img[1], img[0]};
    b = '0;
    for (int s = 5; s >= 0; s--)
      if (p[s] && f[pos[s] +: 3] != 0 && f[pos[s] +: 3] >= b[2:0])
        b = {1'b1, 3'(s), f[pos[s] +: 3]};
    return b;
  endfunction : pick
  task automatic sp(input logic [5:0] p);
    @(posedge core_clk_i);
    pend <= p;
    req.wr <= 0;
    req.rd <= 0;
    due_q.push_back(cyc + 2);
    exp_q.push_back({1'b1, 9'h0, pick(p)});
  endtask : sp
  always @(negedge core_clk_i) begin : mon
    logic [16:0] e;
    while (due_q.size() > 0 && due_q[0] == cyc) begin
      void'(due_q.pop_front());
      e = exp_q.pop_front();
      if (e[16]) chk("irq_sel", {9'h0, sel}, e[15:0]);
      else chk("rdata", rdata, e[15:0]);
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    #4000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1;
    sp(6'h3f);
    for (int a = 0; a < 4; a++) begin
      acc(0, 2'(a), 16'h0);
      acc(1, 2'(a), 16'hffff);
      acc(0, 2'(a), 16'h0);
    end
    for (int i = 0; i < 60; i++) begin
      r = lfsr(r);
      acc(1, r[17:16], r[15:0]);
      acc(0, r[17:16], 16'h0);
      sp(r[29:24]);
    end
    repeat (3) @(posedge core_clk_i);
    wrap_up();
  end
endmodule : test_interrupt_priority_fields
